// >>> include/debug_wire_if.sv
// open-drain debug wire shared by the host end and the target end
// assumes a pull-up: the wire is low when either end drives low
`timescale 1ns/1ps
interface debug_wire_if;
    logic host_out;
    logic host_oe_n;
    logic target_out;
    logic target_oe_n;
    logic pin_level;

    // low drive wins over a speedup pulse, released wire reads high
    assign pin_level = !((!host_oe_n && !host_out) || (!target_oe_n && !target_out));

    modport target (input pin_level, output target_out, output target_oe_n);
    modport host (input pin_level, output host_out, output host_oe_n);
endinterface

// >>> include/debug_wire_pkg.sv
// shared constants and types of the single-wire debug handshake ends
// assumes all timing is counted in serial ticks from a clock divider
package debug_wire_pkg;

    // default clk cycles per serial tick
    localparam int TICK_DIV_DEFAULT = 32'h0000_0010;
    // default worst-case wait when the handshake is off, in ticks
    localparam int WORST_WAIT_TICKS_DEFAULT = 32'h0000_0800;

    // serial tick counts
    localparam logic [7:0] SYNC_REQ_MIN_TICKS = 8'h80;
    localparam logic [7:0] SYNC_DELAY_TICKS = 8'h10;
    localparam logic [7:0] SYNC_RESP_TICKS = 8'h80;
    localparam logic [7:0] ACK_LOW_TICKS = 8'h10;
    localparam logic [7:0] ACK_GAP_TICKS = 8'h20;
    localparam logic [7:0] SPEEDUP_TICKS = 8'h01;
    localparam logic [7:0] SHORT_ABORT_MIN_TICKS = 8'h04;
    // host sync request length, a small margin over the minimum
    localparam logic [7:0] SYNC_REQ_HOST_TICKS = 8'h84;

    // response low time divided by this shift gives clk cycles per tick
    localparam int RATE_SHIFT = $clog2(SYNC_RESP_TICKS);

    // command classes reported by the command decoder
    typedef enum logic [2:0] {
        cmd_read,
        cmd_write,
        cmd_halt,
        cmd_resume,
        cmd_resume_until,
        cmd_single_step,
        cmd_ack_on,
        cmd_ack_off
    } cmd_class_e;

endpackage

// >>> rtl/debug_wire_host.sv
// host end of the debug wire: sync request, abort pulses, ack waiting
// assumes the user side issues one request at a time while busy is low
`timescale 1ns/1ps
module debug_wire_host
    import debug_wire_pkg::*;
#(
    parameter int TICK_DIV = TICK_DIV_DEFAULT,
    parameter int WORST_WAIT_TICKS = WORST_WAIT_TICKS_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // debug wire
    debug_wire_if.host link,
    // requests
    input wire logic sync_req,
    input wire logic abort_req,
    input wire logic ack_wait_req,
    input wire logic ack_expected,
    // results
    output logic busy,
    output logic rate_valid,
    output logic [15:0] rate_cycles,
    output logic wait_done,
    output logic ack_seen
);

    typedef enum logic [2:0] {
        h_idle,
        h_low,
        h_up,
        h_listen_fall,
        h_listen_rise,
        h_wait_fall,
        h_wait_rise,
        h_wait_time
    } host_state_e;

    host_state_e state_reg;
    host_state_e state_next;
    logic [15:0] div_reg;
    logic tick_reg;
    logic [2:0] pin_sync_reg;
    logic pin_reg;
    logic pin_prev_reg;
    logic [15:0] cnt_reg;
    logic [23:0] meas_reg;
    logic sync_mode_reg;
    logic drv_out_reg;
    logic drv_oe_n_reg;
    logic busy_reg;
    logic rate_valid_reg;
    logic [15:0] rate_reg;
    logic wait_done_reg;
    logic ack_seen_reg;

    wire div_last = div_reg == 16'(TICK_DIV - 1);
    // restart on a state change so a low or speedup never falls short of its ticks
    wire div_restart = state_next != state_reg;
    wire pin_agree = pin_sync_reg[1] == pin_sync_reg[2];
    wire fall_w = pin_prev_reg && !pin_reg;
    wire rise_w = !pin_prev_reg && pin_reg;
    wire start_low = sync_req || abort_req;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 16'h0000;
            tick_reg <= 1'b0;
            pin_sync_reg <= 3'h7;
            pin_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else begin
            div_reg <= (div_last || div_restart) ? 16'h0000 : div_reg + 16'h0001;
            tick_reg <= div_last && !div_restart;
            pin_sync_reg <= {pin_sync_reg[1:0], link.pin_level};
            if (pin_agree) begin
                pin_reg <= pin_sync_reg[2];
            end
            pin_prev_reg <= pin_reg;
        end
    end

    // low length: sync request or short abort
    wire [15:0] low_limit = sync_mode_reg ? {8'h00, SYNC_REQ_HOST_TICKS}
        : {8'h00, SHORT_ABORT_MIN_TICKS};
    wire [15:0] cnt_limit = state_reg == h_low ? low_limit
        : state_reg == h_wait_time ? 16'(WORST_WAIT_TICKS)
        : {8'h00, SPEEDUP_TICKS};
    wire cnt_last = tick_reg && cnt_reg == cnt_limit - 16'h0001;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            h_idle, h_wait_fall: begin
                if (start_low) begin
                    state_next = h_low;
                end else if (state_reg == h_wait_fall && fall_w) begin
                    state_next = h_wait_rise;
                end else if (state_reg == h_idle && ack_wait_req) begin
                    state_next = ack_expected ? h_wait_fall : h_wait_time;
                end
            end
            h_low: begin
                if (cnt_last) begin
                    state_next = h_up;
                end
            end
            h_up: begin
                if (cnt_last) begin
                    state_next = sync_mode_reg ? h_listen_fall : h_idle;
                end
            end
            h_listen_fall: begin
                if (fall_w) begin
                    state_next = h_listen_rise;
                end
            end
            h_listen_rise, h_wait_rise: begin
                if (rise_w) begin
                    state_next = h_idle;
                end
            end
            h_wait_time: begin
                if (cnt_last) begin
                    state_next = h_idle;
                end
            end
        endcase
    end

    wire leave_idle = state_reg != h_low && state_next == h_low;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= h_idle;
            cnt_reg <= 16'h0000;
            sync_mode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                cnt_reg <= 16'h0000;
            end else if (tick_reg) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
            if (leave_idle) begin
                sync_mode_reg <= sync_req;
            end
        end
    end

    // response low time in clk cycles, scaled to one tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meas_reg <= 24'h00_0000;
            rate_reg <= 16'h0000;
            rate_valid_reg <= 1'b0;
        end else begin
            meas_reg <= state_reg == h_listen_rise ? meas_reg + 24'h00_0001 : 24'h00_0000;
            rate_valid_reg <= state_reg == h_listen_rise && rise_w;
            if (state_reg == h_listen_rise && rise_w) begin
                rate_reg <= 16'(meas_reg >> RATE_SHIFT);
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            drv_out_reg <= 1'b1;
            drv_oe_n_reg <= 1'b1;
            busy_reg <= 1'b0;
            wait_done_reg <= 1'b0;
            ack_seen_reg <= 1'b0;
        end else begin
            drv_out_reg <= state_next != h_low;
            drv_oe_n_reg <= !(state_next == h_low || state_next == h_up);
            busy_reg <= state_next != h_idle;
            ack_seen_reg <= state_reg == h_wait_rise && rise_w;
            wait_done_reg <= state_reg == h_wait_rise && rise_w
                || state_reg == h_wait_time && cnt_last;
        end
    end

    assign link.host_out = drv_out_reg;
    assign link.host_oe_n = drv_oe_n_reg;
    assign busy = busy_reg;
    assign rate_valid = rate_valid_reg;
    assign rate_cycles = rate_reg;
    assign wait_done = wait_done_reg;
    assign ack_seen = ack_seen_reg;

endmodule

// >>> rtl/debug_wire_target.sv
// target end of the debug wire: handshake pulses, abort and sync response
// assumes a command decoder reports finished commands and a cpu core
// reports background entry and exit, all on clk
`timescale 1ns/1ps
module debug_wire_target
    import debug_wire_pkg::*;
#(
    parameter int TICK_DIV = TICK_DIV_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // debug wire
    debug_wire_if.target link,
    // command decoder
    input wire logic cmd_done,
    input cmd_class_e cmd_class,
    input wire logic access_started,
    input wire logic bus_done,
    // cpu core
    input wire logic cpu_enter_bg,
    input wire logic cpu_exit_bg,
    // status to neighbours
    output logic ack_enabled,
    output logic ack_sent,
    output logic cmd_cancel,
    output logic soft_reset,
    output logic frame_restart,
    output logic sync_busy
);

    typedef enum logic [2:0] {
        st_idle,
        st_low,
        st_wait_high,
        st_delay,
        st_resp_low,
        st_resp_up,
        st_ack_low,
        st_ack_up
    } target_state_e;

    target_state_e state_reg;
    target_state_e state_next;
    logic [15:0] div_reg;
    logic tick_reg;
    logic [2:0] pin_sync_reg;
    logic pin_reg;
    logic pin_prev_reg;
    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] gap_reg;
    logic pend_reg;
    logic ready_reg;
    cmd_class_e class_reg;
    logic ack_en_reg;
    logic drv_out_reg;
    logic drv_oe_n_reg;
    logic ack_sent_reg;
    logic cmd_cancel_reg;
    logic soft_reset_reg;
    logic frame_restart_reg;
    logic sync_busy_reg;
    logic sync_fire;
    logic short_end;
    logic ack_go;
    logic resp_end;
    logic ack_end;

    // serial tick divider, restarted on a state change so no state loses a part tick
    wire div_last = div_reg == 16'(TICK_DIV - 1);
    wire div_restart = state_next != state_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            div_reg <= (div_last || div_restart) ? 16'h0000 : div_reg + 16'h0001;
            tick_reg <= div_last && !div_restart;
        end
    end

    // pin filter: a level counts once the second and third stages agree
    wire pin_agree = pin_sync_reg[1] == pin_sync_reg[2];
    wire fall_w = pin_prev_reg && !pin_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_sync_reg <= 3'h7;
            pin_reg <= 1'b1;
            pin_prev_reg <= 1'b1;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], link.pin_level};
            if (pin_agree) begin
                pin_reg <= pin_sync_reg[2];
            end
            pin_prev_reg <= pin_reg;
        end
    end

    // command class decode
    wire is_rw = class_reg == cmd_read || class_reg == cmd_write;
    wire is_enter = class_reg == cmd_halt || class_reg == cmd_resume_until
        || class_reg == cmd_single_step;
    wire is_run = class_reg == cmd_resume || is_enter && class_reg != cmd_halt;

    // completion events per class
    wire done_w = pend_reg && (is_rw && bus_done
        || is_enter && cpu_enter_bg
        || class_reg == cmd_resume && cpu_exit_bg);

    // the part tick right after the command does not count towards the gap
    wire gap_ok = gap_reg > ACK_GAP_TICKS;
    wire ack_ready_w = pend_reg && ready_reg && ack_en_reg && gap_ok && pin_reg;
    wire short_abort_w = short_end && pend_reg;
    wire keep_cmd_w = is_run || is_rw && access_started;

    // tick count that ends the current state
    wire [7:0] cnt_limit = state_reg == st_low ? SYNC_REQ_MIN_TICKS
        : state_reg == st_delay ? SYNC_DELAY_TICKS
        : state_reg == st_resp_low ? SYNC_RESP_TICKS
        : state_reg == st_ack_low ? ACK_LOW_TICKS
        : SPEEDUP_TICKS;
    wire cnt_last = tick_reg && cnt_reg == cnt_limit - 8'h01;

    always_comb begin
        state_next = state_reg;
        sync_fire = 1'b0;
        short_end = 1'b0;
        ack_go = 1'b0;
        resp_end = 1'b0;
        ack_end = 1'b0;
        unique case (state_reg)
            st_idle: begin
                if (fall_w) begin
                    state_next = st_low;
                end else if (ack_ready_w) begin
                    state_next = st_ack_low;
                    ack_go = 1'b1;
                end
            end
            st_low: begin
                if (pin_reg) begin
                    state_next = st_idle;
                    short_end = 1'b1;
                end else if (cnt_last) begin
                    state_next = st_wait_high;
                    sync_fire = 1'b1;
                end
            end
            st_wait_high: begin
                if (pin_reg) begin
                    state_next = st_delay;
                end
            end
            st_delay: begin
                if (cnt_last) begin
                    state_next = st_resp_low;
                end
            end
            st_resp_low: begin
                if (cnt_last) begin
                    state_next = st_resp_up;
                end
            end
            st_resp_up: begin
                if (cnt_last) begin
                    state_next = st_idle;
                    resp_end = 1'b1;
                end
            end
            st_ack_low: begin
                if (cnt_last) begin
                    state_next = st_ack_up;
                end
            end
            st_ack_up: begin
                if (cnt_last) begin
                    state_next = st_idle;
                    ack_end = 1'b1;
                end
            end
        endcase
    end

    // tick counter restarts on every state change
    always_comb begin
        if (state_next != state_reg) begin
            cnt_next = 8'h00;
        end else if (tick_reg) begin
            cnt_next = cnt_reg + 8'h01;
        end else begin
            cnt_next = cnt_reg;
        end
    end

    wire drive_low = state_next == st_resp_low || state_next == st_ack_low;
    wire drive_up = state_next == st_resp_up || state_next == st_ack_up;
    wire sync_next = state_next == st_wait_high || state_next == st_delay
        || state_next == st_resp_low || state_next == st_resp_up;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= st_idle;
            cnt_reg <= 8'h00;
            drv_out_reg <= 1'b1;
            drv_oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            drv_out_reg <= !drive_low;
            drv_oe_n_reg <= !(drive_low || drive_up);
        end
    end

    // pending command and its acknowledge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_reg <= 1'b0;
            ready_reg <= 1'b0;
            class_reg <= cmd_read;
            gap_reg <= 8'h00;
            ack_en_reg <= 1'b0;
        end else begin
            if (sync_fire || short_abort_w || ack_go) begin
                pend_reg <= 1'b0;
                ready_reg <= 1'b0;
            end else if (done_w) begin
                pend_reg <= ack_en_reg;
                ready_reg <= ack_en_reg;
            end
            if (tick_reg && !gap_ok) begin
                gap_reg <= gap_reg + 8'h01;
            end
            // a new command wins over a same-cycle cancel
            if (cmd_done) begin
                class_reg <= cmd_class;
                gap_reg <= 8'h00;
                pend_reg <= cmd_class != cmd_ack_off;
                ready_reg <= cmd_class == cmd_ack_on;
                if (cmd_class == cmd_ack_on) begin
                    ack_en_reg <= 1'b1;
                end else if (cmd_class == cmd_ack_off) begin
                    ack_en_reg <= 1'b0;
                end
            end
        end
    end

    // status pulses, and the sync_busy level
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_sent_reg <= 1'b0;
            cmd_cancel_reg <= 1'b0;
            soft_reset_reg <= 1'b0;
            frame_restart_reg <= 1'b0;
            sync_busy_reg <= 1'b0;
        end else begin
            ack_sent_reg <= ack_end;
            cmd_cancel_reg <= sync_fire && pend_reg && !keep_cmd_w || short_abort_w;
            soft_reset_reg <= sync_fire;
            frame_restart_reg <= resp_end || short_abort_w && class_reg != cmd_read;
            sync_busy_reg <= sync_next;
        end
    end

    assign link.target_out = drv_out_reg;
    assign link.target_oe_n = drv_oe_n_reg;
    assign ack_enabled = ack_en_reg;
    assign ack_sent = ack_sent_reg;
    assign cmd_cancel = cmd_cancel_reg;
    assign soft_reset = soft_reset_reg;
    assign frame_restart = frame_restart_reg;
    assign sync_busy = sync_busy_reg;

endmodule

// >>> testbench/debug_wire_handshake_sync_bench.sv
// self-checking bench: host end and target end joined by one debug wire
// assumes a 250 MHz clk and a small tick divider to keep the run short
`timescale 1ns/1ps
module debug_wire_handshake_sync_bench;
    import debug_wire_pkg::*;
    localparam int TD = 8;
    localparam int WW = 64;
    localparam int K_CMD = 0, K_BUS = 1, K_IN = 2, K_OUT = 3, K_SYNC = 4, K_ABORT = 5, K_WAIT = 6;
    logic clk, rst, access_started, ack_expected;
    logic cmd_done, bus_done, cpu_enter_bg, cpu_exit_bg, sync_req, abort_req, ack_wait_req;
    logic [6:0] pulses;
    cmd_class_e cmd_class;
    logic ack_enabled, ack_sent, cmd_cancel, soft_reset, frame_restart, sync_busy;
    logic busy, rate_valid, wait_done, ack_seen;
    logic [15:0] rate_cycles;
    logic f_drive, f_cancel, f_soft, f_restart, f_rate, f_done, f_ack, f_sent;
    int n_errors, n_tests, since_cmd, ack_lat;
    cmd_class_e c;

    assign {ack_wait_req, abort_req, sync_req, cpu_exit_bg, cpu_enter_bg, bus_done, cmd_done} = pulses;

    debug_wire_if dw();
    debug_wire_target #(.TICK_DIV(TD)) i_debug_wire_target(.clk(clk), .rst(rst), .link(dw),
        .cmd_done(cmd_done), .cmd_class(cmd_class), .access_started(access_started),
        .bus_done(bus_done), .cpu_enter_bg(cpu_enter_bg), .cpu_exit_bg(cpu_exit_bg),
        .ack_enabled(ack_enabled), .ack_sent(ack_sent), .cmd_cancel(cmd_cancel),
        .soft_reset(soft_reset), .frame_restart(frame_restart), .sync_busy(sync_busy));
    debug_wire_host #(.TICK_DIV(TD), .WORST_WAIT_TICKS(WW)) i_debug_wire_host(.clk(clk),
        .rst(rst), .link(dw), .sync_req(sync_req), .abort_req(abort_req),
        .ack_wait_req(ack_wait_req), .ack_expected(ack_expected), .busy(busy),
        .rate_valid(rate_valid), .rate_cycles(rate_cycles), .wait_done(wait_done),
        .ack_seen(ack_seen));
    debug_wire_handshake_sync_chk #(.TICK_DIV(TD)) i_debug_wire_handshake_sync_chk(.clk(clk),
        .rst(rst), .host_out(dw.host_out), .host_oe_n(dw.host_oe_n),
        .target_out(dw.target_out), .target_oe_n(dw.target_oe_n), .pin_level(dw.pin_level));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // sticky copies of one-clk pulses and of the target drive enable
    always @(posedge clk) begin
        since_cmd <= cmd_done ? 0 : since_cmd + 1;
        if (!dw.target_oe_n && !f_drive) ack_lat <= since_cmd;
        f_drive <= f_drive | !dw.target_oe_n;
        f_cancel <= f_cancel | cmd_cancel;
        f_soft <= f_soft | soft_reset;
        f_restart <= f_restart | frame_restart;
        f_rate <= f_rate | rate_valid;
        f_done <= f_done | wait_done;
        f_ack <= f_ack | ack_seen;
        f_sent <= f_sent | ack_sent;
    end

    function automatic logic sync_cancels(input cmd_class_e k, input logic acc);
        return !(k inside {cmd_resume, cmd_resume_until, cmd_single_step}) &&
            !(acc && k inside {cmd_read, cmd_write});
    endfunction

    function automatic int done_kind(input cmd_class_e k);
        return (k inside {cmd_read, cmd_write}) ? K_BUS : (k == cmd_resume) ? K_OUT : K_IN;
    endfunction

    task automatic final_report();
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic clr();
        {f_drive, f_cancel, f_soft, f_restart, f_rate, f_done, f_ack, f_sent} = '0;
    endtask

    task automatic fire(input int k);
        @(posedge clk);
        #1 pulses[k] = 1'b1;
        @(posedge clk);
        #1 pulses = '0;
    endtask

    // bounded wait: 0 host wait done, 1 sync finished on both ends, 2 host idle
    task automatic wait_until(input int sel, input int bound);
        int i;
        for (i = 0; i < bound; i++) begin
            @(posedge clk);
            #1;
            if (sel == 0 && f_done === 1'b1) break;
            if (sel == 1 && f_rate && f_restart && sync_busy === 1'b0 && busy === 1'b0) break;
            if (sel == 2 && busy === 1'b0) break;
        end
        if (i == bound) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, sel, bound);
            final_report();
        end
    endtask

    task automatic run_cmd(input cmd_class_e k, input int done, input logic exp, input int d);
        cmd_class = k;
        ack_expected = exp;
        clr();
        fire(K_CMD);
        fire(K_WAIT);
        repeat (d) @(posedge clk);
        chk_bit(f_drive, 1'b0);
        if (done >= 0) fire(done);
        wait_until(0, 4000);
        // ack_sent comes at the end of the speedup tick, a few clk after the host has seen the rise
        repeat (2 * TD) @(posedge clk);
        chk_bit(f_ack, exp);
        chk_bit(f_sent, exp);
        if (exp) chk_bit(ack_lat >= 32 * TD, 1'b1);
        $display("test command %0d done", k);
    endtask

    task automatic no_ack_after(input int done);
        clr();
        fire(done);
        repeat (60 * TD) @(posedge clk);
        #1 chk_bit(f_drive, 1'b0);
    endtask

    initial begin
        rst = 1'b1;
        pulses = '0;
        cmd_class = cmd_read;
        access_started = 1'b0;
        ack_expected = 1'b0;
        n_errors = 0;
        n_tests = 0;
        clr();
        void'($urandom(32'h49a8_881b));
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge clk);
        chk_bit(ack_enabled, 1'b0);
        chk_val(rate_cycles, 16'h0000);
        $display("test reset done");
        run_cmd(cmd_read, K_BUS, 1'b0, 50);
        run_cmd(cmd_ack_on, -1, 1'b1, 0);
        chk_bit(ack_enabled, 1'b1);
        for (int i = 0; i < 6; i++) begin
            c = cmd_class_e'(i);
            run_cmd(c, done_kind(c), 1'b1, $urandom_range(300, 0));
        end
        for (int i = 0; i < 6; i++) begin
            c = cmd_class_e'(i);
            cmd_class = c;
            access_started = 1'($urandom_range(1, 0));
            fire(K_CMD);
            clr();
            fire(K_SYNC);
            wait_until(1, 6000);
            chk_bit(f_soft, 1'b1);
            chk_bit(f_cancel, sync_cancels(c, access_started));
            chk_val(rate_cycles, 16'(TD));
            no_ack_after(done_kind(c));
            access_started = 1'b0;
            fire(K_CMD);
            clr();
            fire(K_ABORT);
            wait_until(2, 400);
            repeat (16) @(posedge clk);
            chk_bit(f_cancel, 1'b1);
            chk_bit(f_restart, c != cmd_read);
            no_ack_after(done_kind(c));
            $display("test abort of class %0d done", i);
        end
        run_cmd(cmd_write, K_BUS, 1'b1, 10);
        run_cmd(cmd_ack_off, -1, 1'b0, 0);
        chk_bit(ack_enabled, 1'b0);
        run_cmd(cmd_write, K_BUS, 1'b0, 20);
        final_report();
    end
endmodule

// >>> testbench/debug_wire_handshake_sync_chk.sv
// wire-level checks on the debug wire joining the host end and the target end
// assumes both ends run on clk with the same tick divider
`timescale 1ns/1ps
module debug_wire_handshake_sync_chk #(
    parameter int TICK_DIV = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // wire drives and level
    input wire logic host_out,
    input wire logic host_oe_n,
    input wire logic target_out,
    input wire logic target_oe_n,
    input wire logic pin_level
);
    localparam int TD = TICK_DIV;
    logic [15:0] t_low_reg, t_hi_reg, h_low_reg, h_hi_reg, gap_reg;
    logic long_reg;
    wire t_low = !target_oe_n && !target_out;
    wire t_hi = !target_oe_n && target_out;
    wire h_low = !host_oe_n && !host_out;
    wire h_hi = !host_oe_n && host_out;
    wire long_end = h_hi && (h_low_reg >= 16'(128 * TD));

    // run lengths of each drive phase, in clk cycles
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {t_low_reg, t_hi_reg, h_low_reg, h_hi_reg, gap_reg} <= '0;
            long_reg <= 1'b0;
        end else begin
            t_low_reg <= t_low ? t_low_reg + 16'h0001 : 16'h0000;
            t_hi_reg <= t_hi ? t_hi_reg + 16'h0001 : 16'h0000;
            h_low_reg <= h_low ? h_low_reg + 16'h0001 : 16'h0000;
            h_hi_reg <= h_hi ? h_hi_reg + 16'h0001 : 16'h0000;
            gap_reg <= pin_level ? gap_reg + 16'h0001 : 16'h0000;
            long_reg <= long_end | (long_reg & !t_hi);
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_tgt_low_len: assert property ($rose(t_hi) |->
        (t_low_reg >= 16 * TD && t_low_reg < 17 * TD) ||
        (t_low_reg >= 128 * TD && t_low_reg < 129 * TD))
        else $error("target low run has a wrong length");
    a_tgt_speedup_len: assert property ($rose(target_oe_n) |->
        t_hi_reg >= TD && t_hi_reg < 2 * TD) else $error("target speedup length wrong");
    a_sync_resp_len: assert property ($rose(t_hi) && long_reg |->
        t_low_reg >= 128 * TD && t_low_reg < 129 * TD) else $error("sync response length wrong");
    a_sync_delay_len: assert property ($fell(target_oe_n) && long_reg |->
        gap_reg >= 16 * TD && gap_reg <= 17 * TD + 8) else $error("sync response delay wrong");
    a_host_low_len: assert property ($rose(h_hi) |->
        (h_low_reg >= 4 * TD && h_low_reg < 5 * TD) ||
        (h_low_reg >= 132 * TD && h_low_reg < 133 * TD)) else $error("host low length wrong");
    a_host_speedup_len: assert property ($rose(host_oe_n) |->
        h_hi_reg >= TD && h_hi_reg < 2 * TD) else $error("host speedup length wrong");
    a_reset_released: assert property ($fell(rst) |->
        host_oe_n && target_oe_n) else $error("wire driven after reset");
    a_tgt_starts_low: assert property ($fell(target_oe_n) |-> !target_out)
        else $error("target drive starts high");
    a_host_starts_low: assert property ($fell(host_oe_n) |-> !host_out)
        else $error("host drive starts high");

    c_ack_pulse: cover property ($rose(t_hi) && !long_reg);
    c_sync_resp: cover property ($rose(t_hi) && long_reg);
    c_short_abort: cover property ($rose(h_hi) && h_low_reg < 16'(8 * TD));
endmodule
